// >>> sfcd_decoder.v
// Serial flash command decoder: byte framing, opcode decode and address length selection
// How it works
// (RULE1) Host holds select low from before first clock rise to command end.
// (RULE2) Select returning high ends the command in progress.
// (RULE3) Commands ending off a byte boundary are discarded.
// (RULE4) Host drives select, clock, input; device drives output only for read data.
// (RULE5) Data lanes are driven by one side at a time, never both.
// (RULE6) Dedicated long read opcodes always take a four byte address.
// (RULE7) Long program, erase and lock opcodes always take a four byte address.
// (RULE8) Volatile address-length bit set means legacy opcodes take four address bytes.
// (RULE9) Any reset reloads address-length bit from nonvolatile config two bit one.
// (RULE10) Legacy opcodes follow the address-length mode for address width.
// (RULE11) Identification opcodes 9F, 5A, AF and 4B are decoded.
// (RULE12) Status and configuration register reads return the named register.
// (RULE13) Opcode 01 writes status and config registers; 30 clears error flags.
// (RULE14) 06 and 50 enable writes; 04 disables them.
// (RULE15) B7 enters and E9 leaves four byte address mode, no address.
// (RULE16) Data learning opcodes 41, 43 and 4A are decoded.
// (RULE17) Unknown opcodes are ignored with outputs undriven until select rises.
`timescale 1ns/1ps
`include "sfcd_defs.vh"
module sfcd_decoder #(
  parameter [7:0] NVCFG2_DEFAULT = 8'h00
) (
  input  wire       core_clk,
  input  wire       rstn,
  input  wire       clk_en,
  input  wire       soft_reset,
  input  wire       chip_sel_n,
  input  wire       serial_clk,
  input  wire       serial_in,
  output reg        serial_out,
  output reg        serial_out_oe,
  output reg  [7:0] opcode,
  output reg  [2:0] cmd_class,
  output reg  [2:0] addr_bytes,
  output reg        cmd_valid,
  output reg        cmd_done,
  output reg        cmd_discard,
  output reg  [7:0] status_one,
  output reg  [7:0] status_two,
  output reg  [7:0] config_one,
  output reg  [7:0] volatile_config_two,
  output reg  [7:0] config_three,
  output reg  [7:0] nonvolatile_config_two,
  output reg  [7:0] learning_reg,
  output reg        nv_write_enabled,
  output reg        v_write_enabled
);

  localparam ST_IDLE   = 2'h0;
  localparam ST_ADDR   = 2'h1;
  localparam ST_DATA   = 2'h2;
  localparam ST_IGNORE = 2'h3;

  // ==========================================================
  // Opcode classification
  function [2:0] classify;
    input [7:0] op;
    begin
      case (op)
        // (RULE6) long reads
        8'h13, 8'h0c, 8'h3c, 8'h6c, 8'hbc, 8'hec, 8'hee: classify = `SFCD_CLS_ADDR_LONG;
        // (RULE7) long program, erase, lock
        8'h12, 8'h34, 8'h21, 8'h53, 8'hdc, 8'he0, 8'he1, 8'he2, 8'he3: classify = `SFCD_CLS_ADDR_LONG;
        // (RULE10) legacy addressed opcodes
        8'h5a, 8'h03, 8'h0b, 8'h3b, 8'h6b, 8'heb, 8'hed, 8'h02, 8'h32, 8'h20, 8'h52,
        8'hd8, 8'h65, 8'h71, 8'h44, 8'h42, 8'h48, 8'h3d, 8'h36, 8'h39, 8'hfb: classify = `SFCD_CLS_ADDR_MODE;
        // (RULE11) (RULE12) (RULE16) register style reads
        `SFCD_OP_READ_MAKER_IDENT, `SFCD_OP_READ_QUAD_IDENT, `SFCD_OP_READ_UNIQUE_IDENT,
        `SFCD_OP_READ_STATUS_ONE, `SFCD_OP_READ_STATUS_TWO, `SFCD_OP_READ_CONFIG_ONE,
        `SFCD_OP_READ_CONFIG_TWO, `SFCD_OP_READ_CONFIG_THREE,
        `SFCD_OP_LEARN_PATTERN_READ: classify = `SFCD_CLS_READ_REG;
        // (RULE13) (RULE16) register writes
        `SFCD_OP_WRITE_STATUS_CONFIG, `SFCD_OP_LEARN_REG_PROGRAM,
        `SFCD_OP_LEARN_REG_V_WRITE: classify = `SFCD_CLS_WRITE_REG;
        // (RULE14) (RULE15) single byte commands
        `SFCD_OP_CLEAR_STATUS, `SFCD_OP_NV_WRITE_ENABLE, `SFCD_OP_V_WRITE_ENABLE,
        `SFCD_OP_WRITE_DISABLE, `SFCD_OP_ENTER_LONG_ADDR,
        `SFCD_OP_EXIT_LONG_ADDR: classify = `SFCD_CLS_NOADDR;
        default: classify = `SFCD_CLS_NONE;
      endcase
    end
  endfunction

  // ==========================================================
  // Pin synchronisers
  wire [2:0] pin_sync;
  wire [2:0] pin_rise;
  wire [2:0] pin_fall;

  sfcd_sync #(
    .WIDTH (3)
  ) u_sync (
    .core_clk   (core_clk),
    .rstn       (rstn),
    .clk_en     (clk_en),
    .async_in   ({serial_in, serial_clk, ~chip_sel_n}),
    .sync_out   (pin_sync),
    .rise_pulse (pin_rise),
    .fall_pulse (pin_fall)
  );

  // Select is inverted before syncing so reset matches the idle pin
  wire sel_active = pin_sync[0];
  wire sel_rise   = pin_fall[0];
  wire sck_rise   = pin_rise[1] & sel_active;
  wire sck_fall   = pin_fall[1] & sel_active;
  wire din        = pin_sync[2];

  // ==========================================================
  // Framing state
  reg  [1:0] state_reg;
  reg  [2:0] bit_cnt_reg;
  reg  [7:0] shift_reg;
  reg  [2:0] addr_left_reg;
  reg  [7:0] data_byte_reg;
  reg  [1:0] data_idx_reg;
  reg        byte_any_reg;
  reg  [7:0] tx_reg;
  reg        reload_reg;
  reg [31:0] wr_stage_reg;
  reg  [3:0] wr_mask_reg;

  wire [7:0] shift_next = {shift_reg[6:0], din};
  wire       byte_done  = sck_rise && (bit_cnt_reg == 3'h7);
  wire [2:0] cls_next   = classify(shift_next);
  wire       long_mode  = volatile_config_two[`SFCD_VCFG2_ADDR_LEN_BIT];

  // Register returned by a read command
  reg [7:0] read_value;
  always @* begin
    case (opcode)
      // (RULE12) register read mux
      `SFCD_OP_READ_STATUS_ONE:    read_value = status_one;
      `SFCD_OP_READ_STATUS_TWO:    read_value = status_two;
      `SFCD_OP_READ_CONFIG_ONE:    read_value = config_one;
      `SFCD_OP_READ_CONFIG_TWO:    read_value = volatile_config_two;
      `SFCD_OP_READ_CONFIG_THREE:  read_value = config_three;
      `SFCD_OP_LEARN_PATTERN_READ: read_value = learning_reg;
      default:                     read_value = 8'h00;
    endcase
  end

  // ==========================================================
  // Command sequencer
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      state_reg     <= ST_IDLE;
      bit_cnt_reg   <= 3'h0;
      shift_reg     <= 8'h00;
      addr_left_reg <= 3'h0;
      data_byte_reg <= 8'h00;
      data_idx_reg  <= 2'h0;
      byte_any_reg  <= 1'b0;
      tx_reg        <= 8'h00;
      opcode        <= 8'h00;
      cmd_class     <= `SFCD_CLS_NONE;
      addr_bytes    <= 3'h0;
      cmd_valid     <= 1'b0;
      cmd_done      <= 1'b0;
      cmd_discard   <= 1'b0;
      serial_out    <= 1'b0;
      serial_out_oe <= 1'b0;
    end else if (clk_en) begin
      cmd_valid   <= 1'b0;
      cmd_done    <= 1'b0;
      cmd_discard <= 1'b0;
      // (RULE2) select high ends command
      if (sel_rise) begin
        // (RULE3) partial byte discards
        if (bit_cnt_reg != 3'h0)
          cmd_discard <= 1'b1;
        else if (byte_any_reg && state_reg != ST_IGNORE)
          cmd_done <= 1'b1;
        state_reg     <= ST_IDLE;
        bit_cnt_reg   <= 3'h0;
        byte_any_reg  <= 1'b0;
        data_idx_reg  <= 2'h0;
        serial_out_oe <= 1'b0;
      end else begin
        if (sck_rise) begin
          shift_reg   <= shift_next;
          bit_cnt_reg <= bit_cnt_reg + 3'h1;
        end
        if (byte_done) begin
          byte_any_reg <= 1'b1;
          case (state_reg)
            ST_IDLE: begin
              opcode    <= shift_next;
              cmd_class <= cls_next;
              cmd_valid <= (cls_next != `SFCD_CLS_NONE);
              case (cls_next)
                // (RULE8) address width from mode bit
                `SFCD_CLS_ADDR_MODE: begin
                  addr_bytes    <= long_mode ? `SFCD_LONG_ADDR_BYTES : `SFCD_SHORT_ADDR_BYTES;
                  addr_left_reg <= long_mode ? `SFCD_LONG_ADDR_BYTES : `SFCD_SHORT_ADDR_BYTES;
                  state_reg     <= ST_ADDR;
                end
                // (RULE6) fixed four byte address
                `SFCD_CLS_ADDR_LONG: begin
                  addr_bytes    <= `SFCD_LONG_ADDR_BYTES;
                  addr_left_reg <= `SFCD_LONG_ADDR_BYTES;
                  state_reg     <= ST_ADDR;
                end
                `SFCD_CLS_READ_REG, `SFCD_CLS_WRITE_REG: begin
                  addr_bytes <= 3'h0;
                  state_reg  <= ST_DATA;
                end
                `SFCD_CLS_NOADDR: begin
                  addr_bytes <= 3'h0;
                  state_reg  <= ST_DATA;
                end
                // (RULE17) unknown opcode ignored
                default: begin
                  addr_bytes <= 3'h0;
                  state_reg  <= ST_IGNORE;
                end
              endcase
              tx_reg <= 8'h00;
            end
            ST_ADDR: begin
              addr_left_reg <= addr_left_reg - 3'h1;
              if (addr_left_reg == 3'h1)
                state_reg <= ST_DATA;
            end
            ST_DATA: begin
              data_byte_reg <= shift_next;
              if (data_idx_reg != 2'h3)
                data_idx_reg <= data_idx_reg + 2'h1;
            end
            default: state_reg <= ST_IGNORE;
          endcase
        end
        // Load read data at the first falling edge of each read byte
        if (state_reg == ST_DATA && cmd_class == `SFCD_CLS_READ_REG && sck_fall) begin
          // (RULE4) output driven only for read data
          serial_out_oe <= 1'b1;
          if (bit_cnt_reg == 3'h0) begin
            serial_out <= read_value[7];
            tx_reg     <= {read_value[6:0], 1'b0};
          end else begin
            serial_out <= tx_reg[7];
            tx_reg     <= {tx_reg[6:0], 1'b0};
          end
        end else if (state_reg != ST_DATA || cmd_class != `SFCD_CLS_READ_REG) begin
          // (RULE5) release lane when not returning data
          serial_out_oe <= 1'b0;
        end
      end
    end
  end

  // ==========================================================
  // Register side effects
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      status_one             <= `SFCD_STATUS1_RESET;
      status_two             <= `SFCD_STATUS2_RESET;
      config_one             <= `SFCD_CONFIG1_RESET;
      config_three           <= `SFCD_CONFIG3_RESET;
      volatile_config_two    <= 8'h00;
      nonvolatile_config_two <= 8'h00;
      learning_reg           <= 8'h00;
      nv_write_enabled       <= 1'b0;
      v_write_enabled        <= 1'b0;
      reload_reg             <= 1'b1;
      wr_stage_reg           <= 32'h00000000;
      wr_mask_reg            <= 4'h0;
    end else if (clk_en) begin
      // Staged write bytes are dropped at every frame end
      if (sel_rise)
        wr_mask_reg <= 4'h0;
      // (RULE9) default address length reload
      if (reload_reg || soft_reset) begin
        reload_reg             <= 1'b0;
        nonvolatile_config_two <= NVCFG2_DEFAULT;
        volatile_config_two[`SFCD_VCFG2_ADDR_LEN_BIT] <= NVCFG2_DEFAULT[`SFCD_NVCFG2_ADDR_LEN_BIT];
      end else if (sel_rise && bit_cnt_reg == 3'h0 && state_reg == ST_DATA) begin
        case (opcode)
          // (RULE14) write enable latches
          `SFCD_OP_NV_WRITE_ENABLE: nv_write_enabled <= 1'b1;
          `SFCD_OP_V_WRITE_ENABLE:  v_write_enabled  <= 1'b1;
          `SFCD_OP_WRITE_DISABLE: begin
            nv_write_enabled <= 1'b0;
            v_write_enabled  <= 1'b0;
          end
          // (RULE13) clear error flags
          `SFCD_OP_CLEAR_STATUS: status_two <= status_two & ~`SFCD_STATUS2_ERR_MASK;
          // (RULE15) address mode switch
          `SFCD_OP_ENTER_LONG_ADDR: volatile_config_two[`SFCD_VCFG2_ADDR_LEN_BIT] <= 1'b1;
          `SFCD_OP_EXIT_LONG_ADDR:  volatile_config_two[`SFCD_VCFG2_ADDR_LEN_BIT] <= 1'b0;
          // (RULE16) volatile learning write
          `SFCD_OP_LEARN_REG_V_WRITE: if (v_write_enabled && data_idx_reg != 2'h0) learning_reg <= data_byte_reg;
          `SFCD_OP_LEARN_REG_PROGRAM: begin
            if (nv_write_enabled && data_idx_reg != 2'h0)
              learning_reg <= data_byte_reg;
            nv_write_enabled <= 1'b0;
          end
          // (RULE3) staged write applied on whole bytes only
          `SFCD_OP_WRITE_STATUS_CONFIG: begin
            if (wr_mask_reg[0])
              status_one <= wr_stage_reg[31:24];
            if (wr_mask_reg[1])
              config_one <= wr_stage_reg[23:16];
            if (wr_mask_reg[2])
              volatile_config_two <= wr_stage_reg[15:8];
            if (wr_mask_reg[3])
              config_three <= wr_stage_reg[7:0];
          end
          default: ;
        endcase
      end else if (state_reg == ST_DATA && byte_done && opcode == `SFCD_OP_WRITE_STATUS_CONFIG &&
                   (nv_write_enabled || v_write_enabled)) begin
        // (RULE13) stage status and config bytes until select rises
        case (data_idx_reg)
          2'h0: wr_stage_reg[31:24]  <= shift_next;
          2'h1: wr_stage_reg[23:16]  <= shift_next;
          2'h2: wr_stage_reg[15:8]   <= shift_next;
          default: wr_stage_reg[7:0] <= shift_next;
        endcase
        wr_mask_reg[data_idx_reg] <= 1'b1;
      end
    end
  end

endmodule

// >>> sfcd_decoder_asserts.sv
// Checker for the command decoder ports
`timescale 1ns/1ps
`include "sfcd_defs.vh"
module sfcd_decoder_asserts #(
  parameter [7:0] NVCFG2_DEFAULT = 8'h00
) (
  input logic       core_clk,
  input logic       rstn,
  input logic       chip_sel_n,
  input logic       serial_out_oe,
  input logic [7:0] opcode,
  input logic [2:0] cmd_class,
  input logic [2:0] addr_bytes,
  input logic       cmd_valid,
  input logic       cmd_done,
  input logic       cmd_discard,
  input logic [7:0] volatile_config_two
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);

  // ==========================================================
  // Assertions
  a_oe_idle_low: assert property (chip_sel_n [*8] |-> !serial_out_oe)
    else $error("output enable high while deselected");
  a_end_on_select: assert property ((cmd_done || cmd_discard) |-> chip_sel_n)
    else $error("command end without select high");
  a_done_or_discard: assert property (!(cmd_done && cmd_discard))
    else $error("done and discard together");
  a_long_addr_fixed: assert property (cmd_valid ##1 (opcode inside {8'h13, 8'h0c, 8'h3c, 8'h6c, 8'hbc,
      8'hec, 8'hee, 8'h12, 8'h34, 8'h21, 8'h53, 8'hdc, 8'he0, 8'he1, 8'he2, 8'he3}) |-> addr_bytes == 3'h4)
    else $error("long opcode without four address bytes");
  a_legacy_addr_mode: assert property (cmd_valid ##1 (opcode inside {8'h5a, 8'h03, 8'h0b, 8'h3b, 8'h6b,
      8'heb, 8'hed, 8'h02, 8'h32, 8'h20, 8'h52, 8'hd8, 8'h65, 8'h71, 8'h44, 8'h42, 8'h48, 8'h3d, 8'h36,
      8'h39, 8'hfb}) |-> addr_bytes == (volatile_config_two[0] ? 3'h4 : 3'h3))
    else $error("legacy opcode address width wrong");
  a_no_addr_ops: assert property (cmd_valid ##1 (opcode inside {8'hb7, 8'he9, 8'h4b, 8'h06, 8'h50, 8'h04})
      |-> addr_bytes == 3'h0)
    else $error("no-address opcode expects address");
  a_reg_read_class: assert property (cmd_valid ##1 (opcode inside {8'h05, 8'h07, 8'h35, 8'h15, 8'h33})
      |-> cmd_class == `SFCD_CLS_READ_REG)
    else $error("register read opcode wrong class");
  a_enter_long: assert property (cmd_done && opcode == 8'hb7 |-> ##[0:3] volatile_config_two[0])
    else $error("enter long address not applied");
  a_exit_long: assert property (cmd_done && opcode == 8'he9 |-> ##[0:3] !volatile_config_two[0])
    else $error("exit long address not applied");
  a_reset_load: assert property ($rose(rstn) |-> ##[0:3] volatile_config_two[0] == NVCFG2_DEFAULT[1])
    else $error("address length default not loaded");

  c_done: cover property (cmd_done);
  c_discard: cover property (cmd_discard);
  c_read_drive: cover property ($rose(serial_out_oe));
endmodule

bind sfcd_decoder sfcd_decoder_asserts #(.NVCFG2_DEFAULT(NVCFG2_DEFAULT)) u_chk (
  .core_clk(core_clk), .rstn(rstn), .chip_sel_n(chip_sel_n), .serial_out_oe(serial_out_oe),
  .opcode(opcode), .cmd_class(cmd_class), .addr_bytes(addr_bytes), .cmd_valid(cmd_valid),
  .cmd_done(cmd_done), .cmd_discard(cmd_discard), .volatile_config_two(volatile_config_two));

// >>> sfcd_decoder_tb.sv
// Self-checking testbench for the command decoder
`timescale 1ns/1ps
`include "sfcd_defs.vh"
module sfcd_decoder_tb;
  logic        core_clk = 1'b0;
  logic        rstn     = 1'b0;
  logic        clk_en   = 1'b1;
  logic        soft_reset = 1'b0;
  wire         chip_sel_n, serial_clk, serial_in;
  logic        serial_out, serial_out_oe, cmd_valid, cmd_done, cmd_discard, nv_we, v_we;
  logic [7:0]  opcode, st1, st2, cf1, vcf2, cf3, nvcf2, learn;
  logic [2:0]  cmd_class, addr_bytes;
  logic [39:0] rx;
  logic        oe;
  int          error_cnt = 0, cmp_count = 0, valid_n = 0, done_n = 0, disc_n = 0, cycles = 0;
  logic [7:0]  long_ops [16] = '{8'h13, 8'h0c, 8'h3c, 8'h6c, 8'hbc, 8'hec, 8'hee, 8'h12, 8'h34, 8'h21,
                                 8'h53, 8'hdc, 8'he0, 8'he1, 8'he2, 8'he3};
  logic [7:0]  leg_ops [21] = '{8'h5a, 8'h03, 8'h0b, 8'h3b, 8'h6b, 8'heb, 8'hed, 8'h02, 8'h32, 8'h20, 8'h52,
                                8'hd8, 8'h65, 8'h71, 8'h44, 8'h42, 8'h48, 8'h3d, 8'h36, 8'h39, 8'hfb};

  sfcd_decoder #(.NVCFG2_DEFAULT(8'h02)) uut (
    .core_clk(core_clk), .rstn(rstn), .clk_en(clk_en), .soft_reset(soft_reset), .chip_sel_n(chip_sel_n),
    .serial_clk(serial_clk), .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .opcode(opcode), .cmd_class(cmd_class), .addr_bytes(addr_bytes), .cmd_valid(cmd_valid),
    .cmd_done(cmd_done), .cmd_discard(cmd_discard), .status_one(st1), .status_two(st2), .config_one(cf1),
    .volatile_config_two(vcf2), .config_three(cf3), .nonvolatile_config_two(nvcf2), .learning_reg(learn),
    .nv_write_enabled(nv_we), .v_write_enabled(v_we));

  sfcd_host_model host (
    .core_clk(core_clk), .chip_sel_n(chip_sel_n), .serial_clk(serial_clk), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));

  always #50 core_clk = ~core_clk;

  // ==========================================================
  // Pulse counters and run limit
  always @(posedge core_clk) begin
    cycles++;
    if (cmd_valid === 1'b1) valid_n++;
    if (cmd_done === 1'b1) done_n++;
    if (cmd_discard === 1'b1) disc_n++;
    if (cycles == 60000) begin
      error_cnt++;
      finish_test();
    end
  end

  task automatic chk(input logic [7:0] act, input logic [7:0] exp);
    cmp_count++;
    if (act !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t act=%h exp=%h", $time, act, exp);
    end
  endtask

  task automatic send(input logic [7:0] op);
    host.xfer({32'h0, op}, 8, rx, oe);
  endtask

  task automatic finish_test();
    $display("Comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  // ==========================================================
  // Scenarios
  task automatic t_reset();
    chk({7'h0, vcf2[0]}, 8'h01);
    chk(nvcf2, 8'h02);
    chk({7'h0, serial_out_oe}, 8'h00);
    $display("t_reset done");
  endtask

  task automatic t_addr();
    int v0;
    for (int m = 0; m < 3; m++) begin
      if (m == 1) send(8'he9);
      if (m == 2) send(8'hb7);
      chk({7'h0, vcf2[0]}, (m == 1) ? 8'h00 : 8'h01);
      foreach (leg_ops[i]) begin
        v0 = done_n;
        send(leg_ops[i]);
        chk({5'h0, addr_bytes}, (m == 1) ? 8'h03 : 8'h04);
        chk(opcode, leg_ops[i]);
        chk(8'(done_n - v0), 8'h01);
      end
      foreach (long_ops[i]) begin
        send(long_ops[i]);
        chk({5'h0, addr_bytes}, 8'h04);
        chk({5'h0, cmd_class}, {5'h0, `SFCD_CLS_ADDR_LONG});
      end
    end
    $display("t_addr done");
  endtask

  task automatic t_regs();
    logic [7:0] ops [5] = '{8'h05, 8'h07, 8'h35, 8'h15, 8'h33};
    logic [7:0] exp [5] = '{8'h5c, 8'h00, 8'h3a, 8'h08, 8'h4d};
    send(8'h50);
    chk({7'h0, v_we}, 8'h01);
    host.xfer({8'h01, 8'h5c, 8'h3a, 8'h08, 8'h4d}, 40, rx, oe);
    send(8'h04);
    chk({6'h0, nv_we, v_we}, 8'h00);
    foreach (ops[i]) begin
      host.xfer({24'h0, ops[i], 8'h00}, 16, rx, oe);
      chk(rx[7:0], exp[i]);
      chk({7'h0, oe}, 8'h01);
    end
    send(8'h06);
    chk({7'h0, nv_we}, 8'h01);
    send(8'h30);
    chk(st2 & `SFCD_STATUS2_ERR_MASK, 8'h00);
    send(8'h04);
    $display("t_regs done");
  endtask

  task automatic t_frame_err();
    int v0, d0, x0;
    x0 = disc_n;
    d0 = done_n;
    host.xfer({28'h0, 8'h06, 4'h0}, 12, rx, oe);
    chk(8'(disc_n - x0), 8'h01);
    chk(8'(done_n - d0), 8'h00);
    chk({7'h0, nv_we}, 8'h00);
    v0 = valid_n;
    host.xfer({24'h0, 8'hff, 8'h00}, 16, rx, oe);
    chk(8'(valid_n - v0), 8'h00);
    chk(8'(done_n - d0), 8'h00);
    chk({7'h0, oe}, 8'h00);
    send(8'h50);
    host.xfer({20'h0, 8'h01, 8'ha5, 4'h0}, 20, rx, oe);
    chk(st1, 8'h5c);
    host.xfer({24'h0, 8'h05, 8'h00}, 16, rx, oe);
    chk(rx[7:0], 8'h5c);
    $display("t_frame_err done");
  endtask

  task automatic t_learn();
    int v0;
    send(8'h50);
    host.xfer({24'h0, 8'h4a, 8'h3c}, 16, rx, oe);
    chk(learn, 8'h3c);
    host.xfer({24'h0, 8'h41, 8'h00}, 16, rx, oe);
    chk(rx[7:0], 8'h3c);
    send(8'h06);
    host.xfer({24'h0, 8'h43, 8'hc3}, 16, rx, oe);
    chk(learn, 8'hc3);
    chk({7'h0, nv_we}, 8'h00);
    foreach (long_ops[i]) if (i < 3) begin
      v0 = valid_n;
      send((i == 0) ? 8'h9f : (i == 1) ? 8'haf : 8'h4b);
      chk(8'(valid_n - v0), 8'h01);
    end
    $display("t_learn done");
  endtask

  task automatic t_soft();
    chk({7'h0, vcf2[0]}, 8'h00);
    @(posedge core_clk);
    soft_reset <= 1'b1;
    @(posedge core_clk);
    soft_reset <= 1'b0;
    repeat (4) @(posedge core_clk);
    chk({7'h0, vcf2[0]}, 8'h01);
    $display("t_soft done");
  endtask

  initial begin
    repeat (16) @(posedge core_clk);
    rstn <= 1'b1;
    repeat (4) @(posedge core_clk);
    t_reset();
    t_addr();
    t_regs();
    t_frame_err();
    t_learn();
    t_soft();
    finish_test();
  end
endmodule

// >>> sfcd_defs.vh
// Opcodes, field positions, reset values and bit and byte counts for the command decoder
`ifndef SFCD_DEFS_VH
`define SFCD_DEFS_VH

// Identification
`define SFCD_OP_READ_MAKER_IDENT   8'h9f
`define SFCD_OP_READ_DISCOVERABLE  8'h5a
`define SFCD_OP_READ_QUAD_IDENT    8'haf
`define SFCD_OP_READ_UNIQUE_IDENT  8'h4b
// Register access
`define SFCD_OP_READ_STATUS_ONE    8'h05
`define SFCD_OP_READ_STATUS_TWO    8'h07
`define SFCD_OP_READ_CONFIG_ONE    8'h35
`define SFCD_OP_READ_CONFIG_TWO    8'h15
`define SFCD_OP_READ_CONFIG_THREE  8'h33
`define SFCD_OP_WRITE_STATUS_CONFIG 8'h01
`define SFCD_OP_CLEAR_STATUS       8'h30
`define SFCD_OP_NV_WRITE_ENABLE    8'h06
`define SFCD_OP_V_WRITE_ENABLE     8'h50
`define SFCD_OP_WRITE_DISABLE      8'h04
`define SFCD_OP_ENTER_LONG_ADDR    8'hb7
`define SFCD_OP_EXIT_LONG_ADDR     8'he9
// Data learning
`define SFCD_OP_LEARN_PATTERN_READ 8'h41
`define SFCD_OP_LEARN_REG_PROGRAM  8'h43
`define SFCD_OP_LEARN_REG_V_WRITE  8'h4a

// Command classes
`define SFCD_CLS_NONE      3'h0
`define SFCD_CLS_NOADDR    3'h1
`define SFCD_CLS_ADDR_MODE 3'h2
`define SFCD_CLS_ADDR_LONG 3'h3
`define SFCD_CLS_READ_REG  3'h4
`define SFCD_CLS_WRITE_REG 3'h5

// Address-length bit positions, register reset values and status bit fields
`define SFCD_VCFG2_ADDR_LEN_BIT  0
`define SFCD_NVCFG2_ADDR_LEN_BIT 1
`define SFCD_STATUS1_RESET 8'h00
`define SFCD_STATUS2_RESET 8'h00
`define SFCD_CONFIG1_RESET 8'h00
`define SFCD_CONFIG3_RESET 8'h00
`define SFCD_STATUS2_ERR_MASK 8'h60
`define SFCD_STATUS1_WEL_BIT 1

// Bits per byte and address byte counts
`define SFCD_BITS_PER_BYTE 4'h8
`define SFCD_SHORT_ADDR_BYTES 3'h3
`define SFCD_LONG_ADDR_BYTES  3'h4

`endif

// >>> sfcd_host_model.sv
// Serial host model: drives select, link clock and data in, samples read data
`timescale 1ns/1ps
module sfcd_host_model (
  input  logic core_clk,
  output logic chip_sel_n,
  output logic serial_clk,
  output logic serial_in,
  input  logic serial_out,
  input  logic serial_out_oe
);
  initial begin
    chip_sel_n = 1'b1;
    serial_clk = 1'b0;
    serial_in  = 1'b0;
  end

  task automatic wait_clk(input int n);
    repeat (n) @(posedge core_clk);
  endtask

  // ==========================================================
  // Frame transfer, MSB first, link clock idle low between frames
  // select low before first rise
  task automatic xfer(input logic [39:0] d, input int n, output logic [39:0] rx, output logic oe_seen);
    rx      = '0;
    oe_seen = 1'b0;
    @(posedge core_clk);
    chip_sel_n <= 1'b0;
    wait_clk(4);
    for (int i = 0; i < n; i++) begin
      serial_in  <= d[n-1-i];
      serial_clk <= 1'b0;
      wait_clk(4);
      serial_clk <= 1'b1;
      wait_clk(4);
      // Released line shows the inverse of the held value
      rx      = {rx[38:0], serial_out_oe ? serial_out : ~serial_out};
      oe_seen = oe_seen | serial_out_oe;
    end
    serial_clk <= 1'b0;
    wait_clk(4);
    chip_sel_n <= 1'b1;
    serial_in  <= ~serial_in;
    wait_clk(10);
  endtask
endmodule

// >>> sfcd_sync.v
// Two-stage synchroniser with edge detection for the serial link pins
`timescale 1ns/1ps
module sfcd_sync #(
  parameter WIDTH = 3
) (
  input  wire             core_clk,
  input  wire             rstn,
  input  wire             clk_en,
  input  wire [WIDTH-1:0] async_in,
  output wire [WIDTH-1:0] sync_out,
  output wire [WIDTH-1:0] rise_pulse,
  output wire [WIDTH-1:0] fall_pulse
);

  reg [WIDTH-1:0] meta_reg;
  reg [WIDTH-1:0] stable_reg;
  reg [WIDTH-1:0] last_reg;

  // ==========================================================
  // Stages
  always @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      meta_reg   <= {WIDTH{1'b0}};
      stable_reg <= {WIDTH{1'b0}};
      last_reg   <= {WIDTH{1'b0}};
    end else if (clk_en) begin
      meta_reg   <= async_in;
      stable_reg <= meta_reg;
      last_reg   <= stable_reg;
    end
  end

  assign sync_out   = stable_reg;
  assign rise_pulse = clk_en ? (stable_reg & ~last_reg) : {WIDTH{1'b0}};
  assign fall_pulse = clk_en ? (~stable_reg & last_reg) : {WIDTH{1'b0}};

endmodule
